// ===== pkg/fcs_pkg.sv
// Package: register map, field codes and timing constants of the frequency command selector
package fcs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_ANALOG_OUT_FULL_SCALE = 8'h00;
  localparam logic [7:0] OFF_SECOND_ACCEL_TIME     = 8'h04;
  localparam logic [7:0] OFF_SECOND_DECEL_TIME     = 8'h08;
  localparam logic [7:0] OFF_INTERNAL_FREQUENCY    = 8'h0c;
  localparam logic [7:0] OFF_PRESET_BASE           = 8'h10;
  localparam logic [7:0] OFF_FIRST_ACCEL_TIME      = 8'h30;
  localparam logic [7:0] OFF_FIRST_DECEL_TIME      = 8'h34;
  localparam logic [7:0] OFF_CONFIG                = 8'h38;
  localparam logic [7:0] OFF_STATUS                = 8'h3c;
  localparam logic [7:0] OFF_OUTPUT_FREQ           = 8'h40;
  localparam logic [7:0] OFF_STORED_FREQ           = 8'h44;
  // Config field positions
  localparam int CFG_SPEED_REF_LSB = 0;
  localparam int CFG_IN1_FN_LSB    = 8;
  localparam int CFG_IN2_FN_LSB    = 16;
  localparam int CFG_IN3_FN_LSB    = 24;
  // Codes
  localparam logic [3:0] SPEED_REF_INTERNAL = 4'h1;
  localparam logic [3:0] SPEED_REF_PRESET   = 4'h4;
  localparam logic [4:0] FN_PRESET          = 5'h04;
  localparam logic [4:0] FN_MOP_UP          = 5'h10;
  localparam logic [4:0] FN_MOP_DOWN        = 5'h11;
  // Limits and resets, frequency in 0.1 Hz, percent in 1 %
  localparam logic [15:0] FULL_SCALE_RESET = 16'h0064;
  localparam logic [15:0] FULL_SCALE_MAX   = 16'h0320;
  localparam logic [15:0] FREQ_MAX         = 16'h0fa0;
  localparam logic [15:0] FREQ_INT_RESET   = 16'h0258;
  localparam logic [15:0] RAMP_TIME_RESET  = 16'h0064;
  localparam logic [31:0] CONFIG_RESET     = 32'h00000001;
  localparam logic [15:0] PRESET_RESET [8] = '{16'h0000, 16'h0032, 16'h0064, 16'h00c8,
                                               16'h012c, 16'h0190, 16'h01f4, 16'h0258};
  // Ramp tick: one 0.1 Hz step per (time in 0.1 s) * TICK_CYCLES + 1 cycles, full step 400 Hz
  localparam int CLK_MHZ       = 250;
  localparam int STEP_NS       = 25;
  localparam int TICK_CYCLES   = STEP_NS * CLK_MHZ / 1000;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== logic/fcs_ramp.sv
// Ramp generator: steps the output frequency toward the command at a set rate
`timescale 1ns/1ns
module fcs_ramp
  import fcs_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Command and rates
  input  wire logic [15:0] target,
  input  wire logic [15:0] accel_time,
  input  wire logic [15:0] decel_time,
  // Output
  output logic      [15:0] freq_out
);
  logic [31:0] cnt;
  wire         up       = target > freq_out;
  wire         down     = target < freq_out;
  wire  [31:0] period   = (up ? {16'h0, accel_time} : {16'h0, decel_time}) * 32'(TICK) + 32'd1;
  wire         step     = (cnt + 32'd1) >= period;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt      <= 32'h0;
      freq_out <= 16'h0;
    end
    else if (!(up || down))
      cnt <= 32'h0;
    else if (step)
    begin
      cnt      <= 32'h0;
      freq_out <= up ? freq_out + 16'h1 : freq_out - 16'h1;
    end
    else
      cnt <= cnt + 32'h1;
  end

  a_ramp_toward: assert property (@(posedge aclk) disable iff (!aresetn)
    (freq_out < target) |=> (freq_out >= $past(freq_out)))
    else $error("ramp moved away from command");
endmodule

// ===== logic/fcs_top.sv
// Frequency command selector with AXI4-Lite registers and ramp
// Function
// - Analog output full scale is the source maximum times a 0..800 percent setting, reset 100.
// - With the second ramp set active every speed increase uses the second accel time, jog aside.
// - With the second ramp set active every speed decrease uses the second decel time, jog aside.
// - Speed reference option 1 takes the command from the internal frequency.
// - In program mode with speed reference option 1 the up and down keys move the live internal frequency at once.
// - The internal frequency is stored to nonvolatile memory only on the enter key.
// - Escape before enter restores the stored value, reached through the normal ramp.
// - Any input function at code 16 or 17 makes the internal frequency the motorized pot reference.
// - Internal frequency resets to 60.0 or 0.0 Hz by variant, range 0.0..400.0 Hz in 0.1 Hz.
// - Inputs one to three at function 4 supply a stored preset frequency as command.
// - An active preset input overrides the otherwise selected command source.
// - Preset zero is used only when the speed reference is option 4.
// - Inputs one (lsb), two and three index presets zero to seven.
// - With a preset selected input two low picks ramp pair one, high picks pair two.
// - An active second-ramp input forces ramp pair two over the preset choice.
`timescale 1ns/1ns
module fcs_top
  import fcs_pkg::*;
#(
  parameter logic        IP20_VARIANT = 1'b1,
  parameter int          TICK         = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Digital inputs and keypad
  input  wire logic [2:0]  digital_in,
  input  wire logic        second_ramp_in,
  input  wire logic        jog_active,
  input  wire logic        program_mode,
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        key_enter,
  input  wire logic        key_escape,
  input  wire logic        mop_up_in,
  input  wire logic        mop_down_in,
  // Analog scaling
  input  wire logic [15:0] analog_source_max,
  output logic      [23:0] analog_out_max,
  // Drive outputs
  output logic      [15:0] freq_command,
  output logic      [15:0] output_freq,
  output logic             nvm_store,
  output logic      [15:0] nvm_data,
  output logic             ramp_pair_two
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {FCS_IDLE = 2'b01, FCS_RESP = 2'b10} fcs_bus_e;

  logic [15:0] analog_out_full_scale;
  logic [15:0] second_accel_time;
  logic [15:0] second_decel_time;
  logic [15:0] first_accel_time;
  logic [15:0] first_decel_time;
  logic [15:0] internal_frequency;
  logic [15:0] stored_frequency;
  logic [15:0] preset_frequency [8];
  logic [31:0] config_word;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  fcs_bus_e    wstate;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Preset slot from a byte address inside the preset window
  function automatic logic [2:0] preset_slot(input logic [7:0] a);
    logic [7:0] rel;
    rel         = a - OFF_PRESET_BASE;
    preset_slot = rel[4:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire [3:0] speed_reference_select = config_word[CFG_SPEED_REF_LSB +: 4];
  wire [4:0] input_one_function     = config_word[CFG_IN1_FN_LSB +: 5];
  wire [4:0] input_two_function     = config_word[CFG_IN2_FN_LSB +: 5];
  wire [4:0] input_three_function   = config_word[CFG_IN3_FN_LSB +: 5];

  wire fn_is_mop1 = (input_one_function == FN_MOP_UP) || (input_one_function == FN_MOP_DOWN);
  wire fn_is_mop2 = (input_two_function == FN_MOP_UP) || (input_two_function == FN_MOP_DOWN);
  wire fn_is_mop3 = (input_three_function == FN_MOP_UP) || (input_three_function == FN_MOP_DOWN);
  wire mop_mode   = fn_is_mop1 || fn_is_mop2 || fn_is_mop3;

  // Preset index bits count only on inputs assigned to the preset function
  wire [2:0] preset_index = {digital_in[2] && (input_three_function == FN_PRESET),
                             digital_in[1] && (input_two_function == FN_PRESET),
                             digital_in[0] && (input_one_function == FN_PRESET)};
  wire any_preset_fn = (input_one_function == FN_PRESET) || (input_two_function == FN_PRESET)
                       || (input_three_function == FN_PRESET);
  wire preset_active = (preset_index != 3'h0)
                       || (any_preset_fn && speed_reference_select == SPEED_REF_PRESET);
  wire preset_zero_only = (speed_reference_select == SPEED_REF_PRESET);

  ////////////////////////////////////////////////////////////////////////////////
  // Command selection
  wire [15:0] selected_preset = preset_frequency[preset_index];
  wire [15:0] next_freq_command =
      preset_active ? selected_preset :
      preset_zero_only ? preset_frequency[0] :
      (speed_reference_select == SPEED_REF_INTERNAL || mop_mode) ? internal_frequency :
      16'h0;

  wire pair_two_by_preset = preset_active && preset_index[1];
  wire next_pair_two      = (second_ramp_in || pair_two_by_preset) && !jog_active;
  wire [15:0] accel_sel   = ramp_pair_two ? second_accel_time : first_accel_time;
  wire [15:0] decel_sel   = ramp_pair_two ? second_decel_time : first_decel_time;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      freq_command   <= 16'h0;
      ramp_pair_two  <= 1'b0;
      analog_out_max <= 24'h0;
    end
    else
    begin
      freq_command   <= next_freq_command;
      ramp_pair_two  <= next_pair_two;
      analog_out_max <= 24'((32'(analog_source_max) * 32'(analog_out_full_scale)) / 32'd100);
    end
  end

  fcs_ramp #(.TICK(TICK)) u_ramp
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .target     (freq_command),
    .accel_time (accel_sel),
    .decel_time (decel_sel),
    .freq_out   (output_freq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Keypad and motorized pot adjustment of the internal frequency
  wire keypad_en = program_mode && (speed_reference_select == SPEED_REF_INTERNAL);
  wire inc_req   = (keypad_en && key_up) || (mop_mode && mop_up_in);
  wire dec_req   = (keypad_en && key_down) || (mop_mode && mop_down_in);
  wire [15:0] freq_inc = (internal_frequency < FREQ_MAX) ? internal_frequency + 16'h1 : FREQ_MAX;
  wire [15:0] freq_dec = (internal_frequency != 16'h0) ? internal_frequency - 16'h1 : 16'h0;
  localparam logic [15:0] INT_FREQ_RESET = IP20_VARIANT ? FREQ_INT_RESET : 16'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side
  wire aw_take   = s_axi_awvalid && s_axi_awready;
  wire w_take    = s_axi_wvalid && s_axi_wready;
  wire aw_have   = aw_held || aw_take;
  wire w_have    = w_held || w_take;
  wire [7:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;
  wire do_write  = (wstate == FCS_IDLE) && aw_have && w_have;
  wire wa_preset = (wa >= OFF_PRESET_BASE) && (wa < OFF_FIRST_ACCEL_TIME);
  wire [2:0] wa_idx = preset_slot(wa);
  wire wa_known  = wa_preset || wa == OFF_ANALOG_OUT_FULL_SCALE || wa == OFF_SECOND_ACCEL_TIME
                   || wa == OFF_SECOND_DECEL_TIME || wa == OFF_INTERNAL_FREQUENCY
                   || wa == OFF_FIRST_ACCEL_TIME || wa == OFF_FIRST_DECEL_TIME || wa == OFF_CONFIG;
  wire [31:0] cfg_merged = {ws[3] ? wd[31:24] : config_word[31:24], ws[2] ? wd[23:16] : config_word[23:16],
                            merge16(config_word[15:0], wd, ws)};

  assign s_axi_awready = (wstate == FCS_IDLE) && !aw_held;
  assign s_axi_wready  = (wstate == FCS_IDLE) && !w_held;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      wstate  <= FCS_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (aw_take && !do_write)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take && !do_write)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        wstate       <= FCS_RESP;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wa_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        wstate       <= FCS_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      analog_out_full_scale <= FULL_SCALE_RESET;
      second_accel_time     <= RAMP_TIME_RESET;
      second_decel_time     <= RAMP_TIME_RESET;
      first_accel_time      <= RAMP_TIME_RESET;
      first_decel_time      <= RAMP_TIME_RESET;
      internal_frequency    <= INT_FREQ_RESET;
      stored_frequency      <= INT_FREQ_RESET;
      config_word           <= CONFIG_RESET;
      nvm_store             <= 1'b0;
      nvm_data              <= 16'h0;
      preset_frequency      <= PRESET_RESET;
    end
    else
    begin
      nvm_store <= 1'b0;
      if (do_write && wa == OFF_ANALOG_OUT_FULL_SCALE)
        analog_out_full_scale <= clamp16(merge16(analog_out_full_scale, wd, ws), FULL_SCALE_MAX);
      if (do_write && wa == OFF_SECOND_ACCEL_TIME)
        second_accel_time <= merge16(second_accel_time, wd, ws);
      if (do_write && wa == OFF_SECOND_DECEL_TIME)
        second_decel_time <= merge16(second_decel_time, wd, ws);
      if (do_write && wa == OFF_FIRST_ACCEL_TIME)
        first_accel_time <= merge16(first_accel_time, wd, ws);
      if (do_write && wa == OFF_FIRST_DECEL_TIME)
        first_decel_time <= merge16(first_decel_time, wd, ws);
      if (do_write && wa == OFF_CONFIG)
        config_word <= cfg_merged;
      if (do_write && wa_preset)
        preset_frequency[wa_idx] <= clamp16(merge16(preset_frequency[wa_idx], wd, ws), FREQ_MAX);
      // Internal frequency: bus write, keys, enter commits, escape reverts
      if (do_write && wa == OFF_INTERNAL_FREQUENCY)
      begin
        internal_frequency <= clamp16(merge16(internal_frequency, wd, ws), FREQ_MAX);
        stored_frequency   <= clamp16(merge16(internal_frequency, wd, ws), FREQ_MAX);
      end
      else if (key_enter && keypad_en)
      begin
        stored_frequency <= internal_frequency;
        nvm_store        <= 1'b1;
        nvm_data         <= internal_frequency;
      end
      else if (key_escape && keypad_en)
        internal_frequency <= stored_frequency;
      else if (inc_req && !dec_req)
        internal_frequency <= freq_inc;
      else if (dec_req && !inc_req)
        internal_frequency <= freq_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  wire ra_preset = (s_axi_araddr >= OFF_PRESET_BASE) && (s_axi_araddr < OFF_FIRST_ACCEL_TIME);
  wire [31:0] rd_mux =
      ra_preset ? {16'h0, preset_frequency[preset_slot(s_axi_araddr)]} :
      s_axi_araddr == OFF_ANALOG_OUT_FULL_SCALE ? {16'h0, analog_out_full_scale} :
      s_axi_araddr == OFF_SECOND_ACCEL_TIME ? {16'h0, second_accel_time} :
      s_axi_araddr == OFF_SECOND_DECEL_TIME ? {16'h0, second_decel_time} :
      s_axi_araddr == OFF_INTERNAL_FREQUENCY ? {16'h0, internal_frequency} :
      s_axi_araddr == OFF_FIRST_ACCEL_TIME ? {16'h0, first_accel_time} :
      s_axi_araddr == OFF_FIRST_DECEL_TIME ? {16'h0, first_decel_time} :
      s_axi_araddr == OFF_CONFIG ? config_word :
      s_axi_araddr == OFF_STATUS ? {24'h0, 1'b0, preset_index, mop_mode, preset_active,
                                    ramp_pair_two, 1'b0} :
      s_axi_araddr == OFF_OUTPUT_FREQ ? {output_freq, freq_command} :
      s_axi_araddr == OFF_STORED_FREQ ? {16'h0, stored_frequency} : 32'h0;
  wire ra_known = ra_preset || s_axi_araddr <= OFF_STORED_FREQ && s_axi_araddr[1:0] == 2'b00;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= ra_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_full_scale_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    analog_out_full_scale <= FULL_SCALE_MAX) else $error("full scale above 800");
  a_accel_pair_two: assert property (@(posedge aclk) disable iff (!aresetn)
    ramp_pair_two |-> accel_sel == second_accel_time) else $error("accel pair wrong");
  a_decel_pair_two: assert property (@(posedge aclk) disable iff (!aresetn)
    ramp_pair_two |-> decel_sel == second_decel_time) else $error("decel pair wrong");
  a_internal_source: assert property (@(posedge aclk) disable iff (!aresetn)
    (speed_reference_select == SPEED_REF_INTERNAL && !preset_active) |=> freq_command == $past(internal_frequency))
    else $error("internal source not used");
  a_enter_stores: assert property (@(posedge aclk) disable iff (!aresetn)
    nvm_store |-> nvm_data == stored_frequency) else $error("store mismatch");
  a_escape_revert: assert property (@(posedge aclk) disable iff (!aresetn)
    (keypad_en && key_escape && !key_enter && !do_write) |=> internal_frequency == $past(stored_frequency))
    else $error("escape did not revert");
  a_freq_range: assert property (@(posedge aclk) disable iff (!aresetn)
    internal_frequency <= FREQ_MAX) else $error("internal frequency above 400 Hz");
  a_preset_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (preset_index != 3'h0) |=> freq_command == $past(selected_preset)) else $error("preset not taken");
  a_second_ramp_in: assert property (@(posedge aclk) disable iff (!aresetn)
    (second_ramp_in && !jog_active) |=> ramp_pair_two) else $error("second ramp not forced");
  c_preset_run: cover property (@(posedge aclk) preset_active && preset_index == 3'h7);
  c_enter: cover property (@(posedge aclk) nvm_store);
  c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
endmodule

// ===== bench/fcs_panel.sv
// Model of the drive's input terminals and keypad
`timescale 1ns/1ns
module fcs_panel
(
  // Clock
  input  wire logic       aclk,
  // Terminals and keys
  output logic      [2:0] digital_in,
  output logic            second_ramp_in,
  output logic            jog_active,
  output logic            program_mode,
  output logic      [3:0] keys,
  output logic            mop_up_in,
  output logic            mop_down_in
);
  initial {digital_in, second_ramp_in, jog_active, program_mode, keys, mop_up_in, mop_down_in} = '0;
  // One-cycle press: bit 0 up, 1 down, 2 enter, 3 escape
  task automatic press(input logic [3:0] k);
    @(posedge aclk) keys <= k;
    @(posedge aclk) keys <= 4'h0;
  endtask
  // Level lines, changed at a rising edge
  task automatic set_lines(input logic [2:0] din, input logic sr2, input logic jog, input logic pm);
    @(posedge aclk) {digital_in, second_ramp_in, jog_active, program_mode} <= {din, sr2, jog, pm};
  endtask
  // Raise (dn low) or lower (dn high) input held for n cycles
  task automatic mop_hold(input logic dn, input int n);
    @(posedge aclk) {mop_down_in, mop_up_in} <= {dn, !dn};
    repeat (n) @(posedge aclk);
    {mop_down_in, mop_up_in} <= 2'b00;
  endtask
endmodule

// ===== bench/tb_frequency_command_selector.sv
// Register, selection and ramp tests of the frequency command selector
`timescale 1ns/1ns
module tb_frequency_command_selector
  import fcs_pkg::*;
;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 0, rdata, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, nvm_store, pair2;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] src_max = 0, fcmd, ofreq, nvm_data;
  logic [23:0] ao_max;
  logic [2:0] din;
  logic [3:0] keys;
  logic sr2, jog, pm, mu, md;
  int bad_count = 0, n_compared = 0, cyc = 0, stores = 0;
  always #2 aclk = ~aclk;
  fcs_panel pnl (.aclk(aclk), .digital_in(din), .second_ramp_in(sr2), .jog_active(jog), .program_mode(pm),
    .keys(keys), .mop_up_in(mu), .mop_down_in(md));
  fcs_top #(.TICK(1)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .digital_in(din),
    .second_ramp_in(sr2), .jog_active(jog), .program_mode(pm), .key_up(keys[0]), .key_down(keys[1]),
    .key_enter(keys[2]), .key_escape(keys[3]), .mop_up_in(mu), .mop_down_in(md),
    .analog_source_max(src_max), .analog_out_max(ao_max), .freq_command(fcmd), .output_freq(ofreq),
    .nvm_store(nvm_store), .nvm_data(nvm_data), .ramp_pair_two(pair2));
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (nvm_store === 1'b1) stores <= stores + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge aclk) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    ta = 0;
    tw = 0;
    while (!(ta && tw))
    begin
      @(negedge aclk) {ta, tw} = {ta | awready, tw | wready};
      @(posedge aclk) {awvalid, wvalid} <= {!ta, !tw};
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk) bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk) {araddr, arvalid, rready} <= {a, 2'b11};
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk) arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    @(posedge aclk) rready <= 1'b0;
    {d, resp} = {rdata, rresp};
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_ANALOG_OUT_FULL_SCALE, v); chk("full_scale", v, 32'h64);
    rd(OFF_INTERNAL_FREQUENCY, v); chk("internal", v, 32'h258);
    for (int i = 0; i < 8; i++)
    begin
      rd(OFF_PRESET_BASE + 8'(4 * i), v); chk("preset", v, {16'h0, PRESET_RESET[i]});
    end
    rd(8'h80, v); chk("unmapped", v, 32'h0);
    chk("unmapped_resp", resp, RESP_SLVERR);
    wt(3); chk("cmd_internal", fcmd, 16'h258);
    $display("test reset done");
    src_max <= 16'hc8;
    wr(OFF_ANALOG_OUT_FULL_SCALE, 32'h32); wt(3); chk("ao_half", ao_max, 24'h64);
    chk("bresp", resp, RESP_OKAY);
    wr(OFF_ANALOG_OUT_FULL_SCALE, 32'h320); wt(3); chk("ao_max", ao_max, 24'h640);
    wr(OFF_ANALOG_OUT_FULL_SCALE, 32'h3e8); rd(OFF_ANALOG_OUT_FULL_SCALE, v); chk("fs_cap", v, 32'h320);
    $display("test analog done");
    pnl.set_lines(3'h0, 1'b0, 1'b0, 1'b1);
    pnl.press(4'h1); wt(3); chk("key_up", fcmd, 16'h259);
    rd(OFF_STORED_FREQ, v); chk("not_stored", v, 32'h258);
    chk("no_store", 32'(stores), 32'h0);
    pnl.press(4'h8); wt(3); chk("escape", fcmd, 16'h258);
    pnl.press(4'h1); pnl.press(4'h4); wt(3); chk("store", {nvm_data, 16'(stores)}, {16'h259, 16'h1});
    rd(OFF_STORED_FREQ, v); chk("stored", v, 32'h259);
    pnl.press(4'h2); wt(3); chk("key_down", fcmd, 16'h258);
    pnl.press(4'h8); wt(3); chk("escape_2", fcmd, 16'h259);
    pnl.set_lines(3'h0, 1'b0, 1'b0, 1'b0);
    $display("test keypad done");
    wr(OFF_CONFIG, 32'h00111001);
    pnl.mop_hold(1'b0, 7); wt(3); chk("mop_up", fcmd, 16'h260);
    pnl.mop_hold(1'b1, 2); wt(3); chk("mop_down", fcmd, 16'h25e);
    $display("test mop done");
    wr(OFF_CONFIG, 32'h04040401); wt(3); chk("no_preset", fcmd, 16'h25e);
    for (int i = 1; i < 8; i++)
    begin
      pnl.set_lines(3'(i), 1'b0, 1'b0, 1'b0);
      wt(3);
      chk("preset_cmd", {fcmd, 15'h0, pair2}, {PRESET_RESET[i], 15'h0, 1'(i >> 1)});
    end
    pnl.set_lines(3'h1, 1'b1, 1'b0, 1'b0); wt(3); chk("ramp2_in", pair2, 1'b1);
    pnl.set_lines(3'h1, 1'b1, 1'b1, 1'b0); wt(3); chk("jog", pair2, 1'b0);
    pnl.set_lines(3'h0, 1'b0, 1'b0, 1'b0);
    wr(OFF_CONFIG, 32'h04040404); wt(3); chk("preset0", fcmd, 16'h0);
    $display("test presets done");
    wstrb <= 4'h1;
    wr(OFF_PRESET_BASE + 8'h1c, 32'hffffff2c);
    wstrb <= 4'hf;
    rd(OFF_PRESET_BASE + 8'h1c, v); chk("preset7_lane", v, 32'h22c);
    wr(OFF_FIRST_ACCEL_TIME, 32'h1); wr(OFF_FIRST_DECEL_TIME, 32'h1);
    wr(OFF_CONFIG, 32'h1);
    wt(2);
    for (int i = 0; i < 3000 && ofreq !== fcmd; i++) wt(1);
    chk("ramp_done", ofreq, 16'h25e);
    $display("test ramp done");
    print_verdict();
  end
endmodule
